/* rtl/paip_defines.svh */
`ifndef PAIP_DEFINES_SVH
`define PAIP_DEFINES_SVH

// message framing
`define PAIP_BYTE_REPEAT   4'h9
`define PAIP_LAST_BYTE     4'h8
`define PAIP_LAST_BIT      3'h7
`define PAIP_FIXED_TAIL    3'h1

// receive port clock timing
`define PAIP_MCLK_NS       20
`define PAIP_HIGH_NS       772
`define PAIP_LOW_NS        772
`define PAIP_STRETCH_NS    1544
`define PAIP_HIGH_CYC      ((`PAIP_HIGH_NS + `PAIP_MCLK_NS - 1) / `PAIP_MCLK_NS)
`define PAIP_LOW_CYC       ((`PAIP_LOW_NS + `PAIP_MCLK_NS - 1) / `PAIP_MCLK_NS)
`define PAIP_STRETCH_CYC   ((`PAIP_STRETCH_NS + `PAIP_MCLK_NS - 1) / `PAIP_MCLK_NS)

`endif

/* rtl/paip_pkg.sv */
`default_nettype none
package paip_pkg;
  typedef enum logic {PAIP_TX_HUNT, PAIP_TX_RUN} paip_tx_state_t;
  typedef enum logic {PAIP_RX_LOW, PAIP_RX_HIGH} paip_rx_phase_t;
endpackage : paip_pkg
`default_nettype wire

/* rtl/paip_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "paip_defines.svh"

// Function
// - Each alarm message is one eight-bit byte sent serially nine times in a row per frame.
// - The port clock stretches the cycle that carries bit 8 of every byte.
// - Bits 6 and 7 of every byte are zero and bit 8 is one.
// - On the receive port the device sends the received B3 error count in bits 1 to 4.
// - On the receive port the device sends the RDI value from its received alarms in bit 5.
module paip_top (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  // transmit alarm port from the partner
  input  wire logic       tx_alarm_port_clock_i,
  input  wire logic       tx_alarm_port_frame_i,
  input  wire logic       tx_alarm_port_data_i,
  // values taken from the transmit port
  output logic [3:0]      tx_rei_o,
  output logic            tx_rdi_o,
  output logic            tx_msg_ok_o,
  output logic            tx_msg_err_o,
  // values to send from the receive path
  input  wire logic [3:0] rx_rei_count_i,
  input  wire logic       rx_rdi_i,
  // receive alarm port to the partner
  output logic            rx_alarm_port_clock_o,
  output logic            rx_alarm_port_frame_o,
  output logic            rx_alarm_port_data_o
);

  localparam int HIGH_CYC    = `PAIP_HIGH_CYC;
  localparam int LOW_CYC     = `PAIP_LOW_CYC;
  localparam int STRETCH_CYC = `PAIP_STRETCH_CYC;

  // ---------------- transmit port receiver ----------------
  logic [2:0] tclk_q, tclk_d, tfrm_q, tfrm_d, tdat_q, tdat_d;
  paip_pkg::paip_tx_state_t tst_q, tst_d;
  logic [2:0] tbit_q, tbit_d;
  logic [3:0] tbyte_q, tbyte_d;
  logic [7:0] tsh_q, tsh_d, tnext;
  logic [3:0] trei_d;
  logic       trdi_d, tok_d, terr_d, trise;

  assign trise = tclk_q[1] & ~tclk_q[2];
  assign tnext = {tsh_q[6:0], tdat_q[1]};

  // two-flop sync then edge history
  always_comb begin
    tclk_d = {tclk_q[1:0], tx_alarm_port_clock_i};
    tfrm_d = {tfrm_q[1:0], tx_alarm_port_frame_i};
    tdat_d = {tdat_q[1:0], tx_alarm_port_data_i};
  end

  // bit and byte alignment, field capture
  always_comb begin
    tst_d   = tst_q;
    tbit_d  = tbit_q;
    tbyte_d = tbyte_q;
    tsh_d   = tsh_q;
    trei_d  = tx_rei_o;
    trdi_d  = tx_rdi_o;
    tok_d   = 1'b0;
    terr_d  = 1'b0;
    if (trise) begin
      if (tfrm_q[1]) begin
        tst_d   = paip_pkg::PAIP_TX_RUN;
        tbit_d  = 3'h1;
        tbyte_d = 4'h0;
        tsh_d   = {7'h00, tdat_q[1]};
      end else if (tst_q == paip_pkg::PAIP_TX_RUN) begin
        tsh_d  = tnext;
        tbit_d = tbit_q + 3'h1;
        if (tbit_q == `PAIP_LAST_BIT) begin
          if (tnext[2:0] == `PAIP_FIXED_TAIL) begin
            trei_d = tnext[7:4];
            trdi_d = tnext[3];
            tok_d  = 1'b1;
          end else begin
            terr_d = 1'b1;
          end
          tbyte_d = tbyte_q + 4'h1;
          if (tbyte_q == `PAIP_LAST_BYTE) begin
            tst_d = paip_pkg::PAIP_TX_HUNT;
          end
        end
      end
    end
  end

  // transmit side registers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tclk_q       <= 3'h7; // idle port clock is high, no false edge
      tfrm_q       <= 3'h0;
      tdat_q       <= 3'h0;
      tst_q        <= paip_pkg::PAIP_TX_HUNT;
      tbit_q       <= 3'h0;
      tbyte_q      <= 4'h0;
      tsh_q        <= 8'h00;
      tx_rei_o     <= 4'h0;
      tx_rdi_o     <= 1'b0;
      tx_msg_ok_o  <= 1'b0;
      tx_msg_err_o <= 1'b0;
    end else begin
      tclk_q       <= tclk_d;
      tfrm_q       <= tfrm_d;
      tdat_q       <= tdat_d;
      tst_q        <= tst_d;
      tbit_q       <= tbit_d;
      tbyte_q      <= tbyte_d;
      tsh_q        <= tsh_d;
      tx_rei_o     <= trei_d;
      tx_rdi_o     <= trdi_d;
      tx_msg_ok_o  <= tok_d;
      tx_msg_err_o <= terr_d;
    end
  end

  // ---------------- receive port generator ----------------
  paip_pkg::paip_rx_phase_t rph_q, rph_d;
  logic [6:0] rtmr_q, rtmr_d;
  logic [2:0] rbit_q, rbit_d;
  logic [3:0] rbyte_q, rbyte_d;
  logic [3:0] rrei_q, rrei_d;
  logic       rrdi_q, rrdi_d;
  logic       rclk_d, rfrm_d, rdat_d;
  logic [7:0] rword;

  // byte layout: rei, rdi, then fixed 0,0,1
  always_comb begin
    rword = {rrei_q, rrdi_q, `PAIP_FIXED_TAIL};
  end

  // clock divider with stretched bit 8, data on falling edge
  always_comb begin
    rph_d   = rph_q;
    rtmr_d  = rtmr_q + 7'h01;
    rbit_d  = rbit_q;
    rbyte_d = rbyte_q;
    rrei_d  = rrei_q;
    rrdi_d  = rrdi_q;
    rclk_d  = rx_alarm_port_clock_o;
    rfrm_d  = rx_alarm_port_frame_o;
    rdat_d  = rx_alarm_port_data_o;
    case (rph_q)
      paip_pkg::PAIP_RX_HIGH: begin
        if (rtmr_q == 7'(HIGH_CYC - 1)) begin
          rph_d  = paip_pkg::PAIP_RX_LOW;
          rtmr_d = 7'h00;
          rclk_d = 1'b0;
          if (rbit_q == `PAIP_LAST_BIT) begin
            rbit_d  = 3'h0;
            rbyte_d = (rbyte_q == `PAIP_LAST_BYTE) ? 4'h0 : rbyte_q + 4'h1;
          end else begin
            rbit_d = rbit_q + 3'h1;
          end
          if (rbit_d == 3'h0 && rbyte_d == 4'h0) begin
            rrei_d = rx_rei_count_i;
            rrdi_d = rx_rdi_i;
            rdat_d = rx_rei_count_i[3];
          end else begin
            rdat_d = rword[3'h7 - rbit_d];
          end
          rfrm_d = (rbit_d == 3'h0) && (rbyte_d == 4'h0);
        end
      end
      paip_pkg::PAIP_RX_LOW: begin
        if ((rbit_q == `PAIP_LAST_BIT && rtmr_q == 7'(STRETCH_CYC - 1)) ||
            (rbit_q != `PAIP_LAST_BIT && rtmr_q == 7'(LOW_CYC - 1))) begin
          rph_d  = paip_pkg::PAIP_RX_HIGH;
          rtmr_d = 7'h00;
          rclk_d = 1'b1;
        end
      end
      default: begin
        rph_d  = paip_pkg::PAIP_RX_HIGH;
        rtmr_d = 7'h00;
      end
    endcase
  end

  // receive side registers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rph_q                 <= paip_pkg::PAIP_RX_HIGH;
      rtmr_q                <= 7'h00;
      rbit_q                <= `PAIP_LAST_BIT;
      rbyte_q               <= `PAIP_LAST_BYTE;
      rrei_q                <= 4'h0;
      rrdi_q                <= 1'b0;
      rx_alarm_port_clock_o <= 1'b1;
      rx_alarm_port_frame_o <= 1'b0;
      rx_alarm_port_data_o  <= 1'b1;
    end else begin
      rph_q                 <= rph_d;
      rtmr_q                <= rtmr_d;
      rbit_q                <= rbit_d;
      rbyte_q               <= rbyte_d;
      rrei_q                <= rrei_d;
      rrdi_q                <= rrdi_d;
      rx_alarm_port_clock_o <= rclk_d;
      rx_alarm_port_frame_o <= rfrm_d;
      rx_alarm_port_data_o  <= rdat_d;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // low-phase width counter for the output clock
  logic [7:0] low_cnt_q;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) low_cnt_q <= 8'h00;
    else          low_cnt_q <= rx_alarm_port_clock_o ? 8'h00 : low_cnt_q + 8'h01;
  end

  sequence s_rx_fall;
    $fell(rx_alarm_port_clock_o);
  endsequence

  sequence s_tx_last_bit;
    trise && !tfrm_q[1] && tst_q == paip_pkg::PAIP_TX_RUN && tbit_q == 3'h7;
  endsequence

  AST_RX_STRETCH:
    assert property ($rose(rx_alarm_port_clock_o) |->
      low_cnt_q == 8'((rbit_q == 3'h7) ? STRETCH_CYC : LOW_CYC))
    else $error("receive port low phase has wrong width");
  AST_RX_TAIL:
    assert property (s_rx_fall ##0 (rbit_q >= 3'h5) |->
      rx_alarm_port_data_o == (rbit_q == 3'h7))
    else $error("receive port fixed bits wrong");
  AST_RX_REI:
    assert property (s_rx_fall ##0 (rbit_q < 3'h4) |->
      rx_alarm_port_data_o == rrei_q[2'(3 - rbit_q)])
    else $error("receive port REI bit wrong");
  AST_RX_RDI:
    assert property (s_rx_fall ##0 (rbit_q == 3'h4) |-> rx_alarm_port_data_o == rrdi_q)
    else $error("receive port RDI bit wrong");
  AST_RX_FRAME:
    assert property (rx_alarm_port_frame_o |-> rbit_q == 3'h0 && rbyte_q == 4'h0)
    else $error("frame pulse away from first bit");
  AST_RX_NINE:
    assert property (s_rx_fall ##0 (rbit_q == 3'h0) |->
      rbyte_q == (($past(rbyte_q) == 4'h8) ? 4'h0 : $past(rbyte_q) + 4'h1))
    else $error("receive byte count does not wrap at nine");
  AST_TX_ALIGN:
    assert property (trise && tfrm_q[1] |=> tbit_q == 3'h1 && tbyte_q == 4'h0)
    else $error("transmit port not aligned to frame");
  AST_TX_TAKE:
    assert property (s_tx_last_bit ##0 (tnext[2:0] == 3'h1) |=>
      tx_msg_ok_o && tx_rei_o == $past(tnext[7:4]) && tx_rdi_o == $past(tnext[3]))
    else $error("transmit REI or RDI not taken");
  AST_TX_BADTAIL:
    assert property (s_tx_last_bit ##0 (tnext[2:0] != 3'h1) |=>
      tx_msg_err_o && !tx_msg_ok_o && $stable(tx_rei_o))
    else $error("bad byte tail not flagged");
  AST_TX_HOLD:
    assert property (!trise |=> $stable(tx_rei_o) && $stable(tx_rdi_o))
    else $error("transmit values changed without a bit");

endmodule : paip_top
`default_nettype wire

/* tb/paip_partner.sv */
`timescale 1ns/1ns
`default_nettype none
// far side of the transmit alarm port: 8 mclk bit cell, bit 8 low phase doubled
module paip_partner (
  // system clock
  input  wire logic mclk_i,
  // transmit alarm port toward the device
  output logic      tx_alarm_port_clock_o,
  output logic      tx_alarm_port_frame_o,
  output logic      tx_alarm_port_data_o
);
  // idle: clock stands high, no frame
  initial begin
    tx_alarm_port_clock_o = 1'b1;
    tx_alarm_port_frame_o = 1'b0;
    tx_alarm_port_data_o  = 1'b0;
  end
  // one message frame, nine copies of the byte, msb first
  task automatic send_frame(input logic [3:0] rei, input logic rdi,
                            input logic [2:0] tail, input logic framed);
    logic [7:0] byte_v;
    byte_v = {rei, rdi, tail};
    for (int b = 0; b < 9; b++) begin
      for (int i = 0; i < 8; i++) begin
        @(posedge mclk_i);
        tx_alarm_port_clock_o <= 1'b0;
        tx_alarm_port_data_o  <= byte_v[7-i];
        tx_alarm_port_frame_o <= framed && b == 0 && i == 0;
        repeat ((i == 7) ? 8 : 4) @(posedge mclk_i);
        tx_alarm_port_clock_o <= 1'b1;
        repeat (3) @(posedge mclk_i);
      end
    end
    // released data line shows the inverse of the last bit
    @(posedge mclk_i);
    tx_alarm_port_data_o  <= ~byte_v[0];
    tx_alarm_port_frame_o <= 1'b0;
  endtask : send_frame
endmodule : paip_partner
`default_nettype wire

/* tb/paip_top_test.sv */
`timescale 1ns/1ns
`default_nettype none
module paip_top_test;
  logic       mclk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       tx_alarm_port_clock_i, tx_alarm_port_frame_i, tx_alarm_port_data_i;
  logic [3:0] tx_rei_o;
  logic       tx_rdi_o, tx_msg_ok_o, tx_msg_err_o;
  logic [3:0] rx_rei_count_i = 4'h0;
  logic       rx_rdi_i = 1'b0;
  logic       rx_alarm_port_clock_o, rx_alarm_port_frame_o, rx_alarm_port_data_o;
  int         n_mismatch = 0, total_checks = 0, n_ok = 0, n_err = 0;
  logic [4:0] last_v = 5'h00;

  paip_top paip_top_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .tx_alarm_port_clock_i(tx_alarm_port_clock_i), .tx_alarm_port_frame_i(tx_alarm_port_frame_i),
    .tx_alarm_port_data_i(tx_alarm_port_data_i), .tx_rei_o(tx_rei_o), .tx_rdi_o(tx_rdi_o),
    .tx_msg_ok_o(tx_msg_ok_o), .tx_msg_err_o(tx_msg_err_o), .rx_rei_count_i(rx_rei_count_i),
    .rx_rdi_i(rx_rdi_i), .rx_alarm_port_clock_o(rx_alarm_port_clock_o),
    .rx_alarm_port_frame_o(rx_alarm_port_frame_o), .rx_alarm_port_data_o(rx_alarm_port_data_o));
  paip_partner paip_partner_inst (.mclk_i(mclk_i),
    .tx_alarm_port_clock_o(tx_alarm_port_clock_i), .tx_alarm_port_frame_o(tx_alarm_port_frame_i),
    .tx_alarm_port_data_o(tx_alarm_port_data_i));

  // 50 MHz clock
  always #10 mclk_i = ~mclk_i;
  // count result pulses
  always @(posedge mclk_i) begin
    if (tx_msg_ok_o === 1'b1) n_ok++;
    if (tx_msg_err_o === 1'b1) n_err++;
  end
  task tick;
    @(posedge mclk_i);
    #1;
  endtask : tick
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one transmit frame and its expected outcome
  task tx_case(input logic [3:0] rei, input logic rdi, input logic [2:0] tail,
               input logic framed);
    logic good;
    good = framed && tail == 3'b001;
    n_ok = 0;
    n_err = 0;
    paip_partner_inst.send_frame(rei, rdi, tail, framed);
    repeat (10) tick();
    if (good) last_v = {rei, rdi};
    check("ok_count", 8'(n_ok), good ? 8'h09 : 8'h00);
    check("err_count", 8'(n_err), (framed && !good) ? 8'h09 : 8'h00);
    check("tx_values", {3'h0, tx_rei_o, tx_rdi_o}, {3'h0, last_v});
  endtask : tx_case
  task sc_tx_good;
    tx_case(4'ha, 1'b1, 3'b001, 1'b1);
    tx_case(4'h5, 1'b0, 3'b001, 1'b1);
    tx_case(4'hf, 1'b1, 3'b001, 1'b1);
  endtask : sc_tx_good
  task sc_tx_bad_tail;
    tx_case(4'h0, 1'b0, 3'b011, 1'b1);
    tx_case(4'h3, 1'b0, 3'b000, 1'b1);
  endtask : sc_tx_bad_tail
  task sc_tx_unframed;
    tx_case(4'h6, 1'b0, 3'b001, 1'b0);
  endtask : sc_tx_unframed
  // receive port: one whole frame, bytes and cell lengths
  task sc_rx_port(input logic [3:0] rei, input logic rdi);
    logic [7:0] got;
    int lo, hi, k;
    @(posedge mclk_i);
    rx_rei_count_i <= rei;
    rx_rdi_i <= rdi;
    k = 0;
    while (rx_alarm_port_frame_o !== 1'b0 && k < 7000) begin tick(); k++; end
    while (rx_alarm_port_frame_o !== 1'b1 && k < 14000) begin tick(); k++; end
    check("rx_frame_found", 8'(k < 14000), 8'h01);
    for (int b = 0; b < 9; b++) begin
      for (int i = 0; i < 8; i++) begin
        lo = 0;
        hi = 0;
        while (rx_alarm_port_clock_o === 1'b0 && lo < 100) begin tick(); lo++; end
        got[7-i] = rx_alarm_port_data_o;
        check("rx_frame", {7'h00, rx_alarm_port_frame_o}, (b == 0 && i == 0) ? 8'h01 : 8'h00);
        while (rx_alarm_port_clock_o === 1'b1 && hi < 100) begin tick(); hi++; end
        check("rx_low_cycles", 8'(lo), (i == 7) ? 8'h4e : 8'h27);
        check("rx_high_cycles", 8'(hi), 8'h27);
      end
      check("rx_byte", got, {rei, rdi, 3'b001});
    end
  endtask : sc_rx_port
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  // watchdog
  initial begin
    repeat (60000) @(posedge mclk_i);
    n_mismatch++;
    end_sim();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    sc_tx_good();
    sc_tx_bad_tail();
    sc_tx_unframed();
    sc_rx_port(4'h9, 1'b1);
    sc_rx_port(4'h6, 1'b0);
    end_sim();
  end
endmodule : paip_top_test
`default_nettype wire
